// *** hdl/pss_sequencer.sv ***
// Print start sequencer: start trigger, print order output, generation
// and error reporting for a direct print module.
// Assumes print/generation done pulses and fault pulses come on i_clk.
// Assumes the configuration straps stay still while an order runs.
`timescale 1ns/1ns
`include "pss_regs.svh"

// Overview of operation
// - Dynamic mode with edge trigger takes only the start input's transition as a print start.
// - Trigger selectable as rising edge or high level.
// - Static mode: held level continues into next layout once it is generated.
// - Static mode: level removed, finish current layout then wait.
// - Starts arriving while printing are ignored.
// - Print order output stays active until all layouts are printed.
// - Standard memory: next order generated only after previous finished feeding.
// - Extended memory: generate at order start, prepare next before current ends.
// - Dynamic mode: layout spacing follows start pulse interval, not layout length.
// - Identical layouts generated once; variable layouts regenerated each time.
// - Multi-layout order received once; receiving may overlap printing.
// - Serial faults report codes 11 framing, 12 parity, 13 data lost.
// - Ribbon running out during an order reports code 10.
// - Label measurement finding no label reports code 8.
module pss_sequencer (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire pss_pkg::pss_cfg_t i_cfg,
  input wire logic i_order_valid,
  input wire logic i_gen_done,
  input wire logic i_layout_done,
  input wire pss_pkg::pss_fault_t i_fault,
  output logic o_print_order,
  output logic o_print,
  output logic o_generate,
  output logic o_feed,
  output logic o_receive,
  output logic o_start_ignored,
  output logic o_err_valid,
  output logic [7:0] o_err_code
);
  import pss_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Whole block state in one register, next value built below
  pss_st_t st_reg;
  pss_st_t st_next;

  // ----------------------------------------------------------------
  // Decoding functions
  // ----------------------------------------------------------------
  // Fault priority: serial link first, then mechanics
  function automatic logic [7:0] pss_err_of(input pss_fault_t f);
    logic [7:0] c;
    c = `PSS_ERR_NONE;
    if (f.label_missing) begin
      c = `PSS_ERR_NO_LABEL;
    end
    if (f.ribbon_out) begin
      c = `PSS_ERR_NO_RIBBON;
    end
    if (f.data_lost) begin
      c = `PSS_ERR_DATA_LOST;
    end
    if (f.parity) begin
      c = `PSS_ERR_PARITY;
    end
    if (f.framing) begin
      c = `PSS_ERR_FRAMING;
    end
    return c;
  endfunction

  // Ribbon shortage outside an order is not a print fault
  function automatic pss_fault_t pss_mask_fault(input pss_fault_t f, input logic in_order);
    pss_fault_t m;
    m = f;
    m.ribbon_out = f.ribbon_out & in_order;
    return m;
  endfunction

  // Any fault event present
  function automatic logic pss_any_fault(input pss_fault_t f);
    return f.framing | f.parity | f.data_lost | f.ribbon_out | f.label_missing;
  endfunction

  // Countdown has reached the final layout of the order
  function automatic logic pss_is_last(input logic [7:0] left);
    return left == `PSS_CNT_ONE;
  endfunction

  // State compare, used for every state flag
  function automatic logic pss_in_state(input pss_state_t cur, input pss_state_t want);
    return cur == want;
  endfunction

  // ----------------------------------------------------------------
  // Start synchroniser
  // ----------------------------------------------------------------
  // Host start is asynchronous; stage 0 feeds only stage 1
  logic [`PSS_SYNC_PREV:`PSS_SYNC_IN] sync_shift;

  assign sync_shift[`PSS_SYNC_IN] = i_start;
  for (genvar g = `PSS_SYNC_OUT; g <= `PSS_SYNC_PREV; g++) begin : g_sync
    assign sync_shift[g] = st_reg.start_sync[g - `PSS_SYNC_OUT];
  end

  // ----------------------------------------------------------------
  // Start qualification
  // ----------------------------------------------------------------
  logic start_lvl;
  logic start_rise;
  logic level_mode;
  logic start_ok;

  assign start_lvl = st_reg.start_sync[`PSS_SYNC_OUT];
  // Edge only: a held level must not start a second print
  assign start_rise = st_reg.start_sync[`PSS_SYNC_OUT]
                      & ~st_reg.start_sync[`PSS_SYNC_PREV];
  // Static mode always works on the level
  assign level_mode = i_cfg.static_mode | i_cfg.level_trigger;
  assign start_ok = level_mode ? start_lvl : start_rise;

  // ----------------------------------------------------------------
  // Order progress
  // ----------------------------------------------------------------
  logic last_layout;
  logic gen_finishing;
  logic reuse_layout;
  logic early_gen;
  logic next_ready;

  assign last_layout = pss_is_last(st_reg.left);
  // Generation ending in this very cycle counts as prepared
  assign gen_finishing = i_gen_done & st_reg.gen_out;
  // Without module variables all layouts are the same image
  assign reuse_layout = ~i_cfg.has_variables;
  // Extended memory prepares the next layout while printing
  assign early_gen = i_cfg.extended_mem & ~last_layout;
  assign next_ready = st_reg.prepared | gen_finishing;

  // ----------------------------------------------------------------
  // Fault qualification
  // ----------------------------------------------------------------
  pss_fault_t fault_seen;
  logic fault_any;

  assign fault_seen = pss_mask_fault(i_fault, st_reg.order_out);
  assign fault_any = pss_any_fault(fault_seen);

  // ----------------------------------------------------------------
  // State decoding
  // ----------------------------------------------------------------
  logic in_idle;
  logic in_gen;
  logic in_ready;
  logic in_print;
  logic order_take;
  logic gen_take;
  logic start_take;
  logic start_early;

  assign in_idle = pss_in_state(st_reg.state, PSS_IDLE);
  assign in_gen = pss_in_state(st_reg.state, PSS_GEN);
  assign in_ready = pss_in_state(st_reg.state, PSS_READY);
  assign in_print = pss_in_state(st_reg.state, PSS_PRINT);
  // Order data is taken only between orders
  assign order_take = in_idle & i_order_valid;
  assign gen_take = in_gen & i_gen_done;
  // A start counts only once the layout is prepared
  assign start_take = in_ready & start_ok & st_reg.prepared;
  // Start edge during a print is dropped and reported
  assign start_early = in_print & start_rise;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.start_sync = sync_shift;
    st_next.ignored = 1'b0;
    st_next.err_valid = 1'b0;

    case (st_reg.state)
      // Waiting for order data from the host
      PSS_IDLE: begin
        st_next.receive_out = 1'b1;
        // Order data arrives once for all its layouts
        if (order_take) begin
          st_next.left = i_cfg.layouts;
          st_next.order_loaded = 1'b1;
          st_next.receive_out = 1'b0;
          st_next.generated_once = 1'b0;
          st_next.order_out = 1'b1;
          st_next.gen_out = 1'b1;
          st_next.state = PSS_GEN;
        end
      end

      // Layout image being built
      PSS_GEN: begin
        if (gen_take) begin
          st_next.gen_out = 1'b0;
          st_next.generated_once = 1'b1;
          st_next.prepared = 1'b1;
          st_next.state = PSS_READY;
        end
      end

      // Prepared layout waiting for a qualified start
      PSS_READY: begin
        // Layout spacing set by start timing alone
        if (start_take) begin
          st_next.prepared = 1'b0;
          st_next.print_out = 1'b1;
          st_next.feed_out = 1'b1;
          st_next.state = PSS_PRINT;
          // Extended memory generates during the print
          if (early_gen) begin
            st_next.gen_out = ~reuse_layout;
            st_next.prepared = reuse_layout;
          end
          // Receiving overlaps printing with extended memory
          if (i_cfg.extended_mem) begin
            st_next.receive_out = 1'b1;
          end
        end
      end

      // Layout on the material
      PSS_PRINT: begin
        // Host started too early
        if (start_early) begin
          st_next.ignored = 1'b1;
        end
        if (gen_finishing) begin
          st_next.gen_out = 1'b0;
          st_next.prepared = 1'b1;
        end
        if (i_layout_done && st_reg.order_loaded) begin
          st_next.print_out = 1'b0;
          st_next.feed_out = 1'b0;
          st_next.left = st_reg.left - `PSS_CNT_ONE;
          if (last_layout) begin
            // Order complete only after full feed
            st_next.order_out = 1'b0;
            st_next.order_loaded = 1'b0;
            st_next.prepared = 1'b0;
            st_next.gen_out = 1'b0;
            st_next.state = PSS_IDLE;
          end else if (next_ready) begin
            // Held level resumes at once in static mode
            st_next.state = PSS_READY;
          end else if (reuse_layout && st_reg.generated_once) begin
            // Same image again, no new generation
            st_next.gen_out = 1'b0;
            st_next.prepared = 1'b1;
            st_next.state = PSS_READY;
          end else begin
            // Variable parts built anew for each layout
            st_next.gen_out = 1'b1;
            st_next.prepared = 1'b0;
            st_next.state = PSS_GEN;
          end
        end
      end

      default: begin
        st_next.state = PSS_IDLE;
      end
    endcase

    // Fault report, one pulse with its code
    if (fault_any) begin
      st_next.err_valid = 1'b1;
      st_next.err_code = pss_err_of(fault_seen);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Asynchronous clear drives every output low
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Order, print and handshake levels
  assign o_print_order = st_reg.order_out;
  assign o_print = st_reg.print_out;
  assign o_generate = st_reg.gen_out;
  assign o_feed = st_reg.feed_out;
  assign o_receive = st_reg.receive_out;
  // Single-cycle pulses and the held fault code
  assign o_start_ignored = st_reg.ignored;
  assign o_err_valid = st_reg.err_valid;
  assign o_err_code = st_reg.err_code;

endmodule

// *** hdl/pss_regs.svh ***
// Constants of the print start sequencer: error codes and timing.
// Assumes inclusion by the package and the design file only.
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

`define PSS_ERR_NONE 8'h00
`define PSS_ERR_NO_LABEL 8'h08
`define PSS_ERR_NO_RIBBON 8'h0A
`define PSS_ERR_FRAMING 8'h0B
`define PSS_ERR_PARITY 8'h0C
`define PSS_ERR_DATA_LOST 8'h0D
`define PSS_MIN_PULSE_MS 50
`define PSS_CNT_ZERO 8'h00
`define PSS_CNT_ONE 8'h01
`define PSS_SYNC_IN 0
`define PSS_SYNC_OUT 1
`define PSS_SYNC_PREV 2

`endif

// *** hdl/pss_pkg.sv ***
// Types of the print start sequencer.
// Assumes pss_regs.svh is on the include path.
`include "pss_regs.svh"

package pss_pkg;

  typedef enum logic [1:0] {
    PSS_IDLE = 2'h0,
    PSS_GEN = 2'h1,
    PSS_READY = 2'h3,
    PSS_PRINT = 2'h2
  } pss_state_t;

  // Configuration straps from the machine set-up
  typedef struct packed {
    logic static_mode;
    logic level_trigger;
    logic extended_mem;
    logic has_variables;
    logic [7:0] layouts;
  } pss_cfg_t;

  // Fault events from the mechanics and the serial receiver
  typedef struct packed {
    logic framing;
    logic parity;
    logic data_lost;
    logic ribbon_out;
    logic label_missing;
  } pss_fault_t;

  typedef struct packed {
    pss_state_t state;
    logic [2:0] start_sync;
    logic [7:0] left;
    logic prepared;
    logic generated_once;
    logic order_loaded;
    logic order_out;
    logic print_out;
    logic gen_out;
    logic feed_out;
    logic receive_out;
    logic err_valid;
    logic [7:0] err_code;
    logic ignored;
  } pss_st_t;

endpackage

// *** testbench/pss_seq_checker.sv ***
// Checker: port timing of the print start sequencer.
// Assumes one clock domain and binding to pss_sequencer.
`timescale 1ns/1ns
module pss_seq_checker
  import pss_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_order_valid,
  input wire logic i_layout_done,
  input wire pss_pkg::pss_fault_t i_fault,
  input wire logic o_print_order,
  input wire logic o_print,
  input wire logic o_start_ignored,
  input wire logic o_err_valid,
  input wire logic [7:0] o_err_code
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_err(logic [7:0] c);
    o_err_valid && o_err_code == c;
  endsequence
  property p_frm; i_fault.framing |=> s_err(8'h0B); endproperty
  a_frm: assert property (p_frm) else $error("framing code");
  property p_rib; i_fault == 5'h02 && o_print_order |=> s_err(8'h0A); endproperty
  a_rib: assert property (p_rib) else $error("ribbon code");
  property p_lab; i_fault == 5'h01 |=> s_err(8'h08); endproperty
  a_lab: assert property (p_lab) else $error("label code");
  property p_ord; $rose(o_print_order) |-> $past(i_order_valid); endproperty
  a_ord: assert property (p_ord) else $error("order rise");
  property p_hold; o_print |-> o_print_order; endproperty
  a_hold: assert property (p_hold) else $error("order dropped");
  property p_fin; $fell(o_print) |-> $past(i_layout_done); endproperty
  a_fin: assert property (p_fin) else $error("print cut short");
  property p_sync; $rose(o_print) |-> $past(i_start, 3); endproperty
  a_sync: assert property (p_sync) else $error("early print");
  property p_ign; o_start_ignored |-> $past(o_print); endproperty
  a_ign: assert property (p_ign) else $error("bad ignore");
endmodule

bind pss_sequencer pss_seq_checker i_chk (.*);

// *** testbench/pss_host_model.sv ***
// Host machine model: start pulses and held start level.
// Assumes requests from the bench change at the falling edge.
`timescale 1ns/1ns
module pss_host_model (
  input wire logic i_clk,
  input wire logic i_pulse,
  input wire logic i_hold,
  output logic o_start = 1'b0
);
  int cnt = 0;
  logic hold_q = 1'b0;
  always @(posedge i_clk) begin
    cnt <= i_pulse ? 6 : (cnt > 0 ? cnt - 1 : 0); // Scaled minimum width
    hold_q <= i_hold;
  end
  always @(negedge i_clk) o_start <= hold_q || cnt > 0;
endmodule

// *** testbench/pss_sequencer_tb.sv ***
// Bench: orders, starts and faults; counts checked against a model.
// Assumes the package, sequencer, host model and checker are compiled.
`timescale 1ns/1ns
module pss_sequencer_tb;
  import pss_pkg::*;
  logic clk = 0, rst_n = 0, ov = 0, gd = 0, ld = 0, pl = 0, hd = 0, st;
  logic po, pr, gn, rc, ig, ev, fd, pr_q = 0;
  logic [7:0] ec;
  logic [7:0] cd [5] = '{8'h0B, 8'h0C, 8'h0D, 8'h0A, 8'h08};
  pss_cfg_t cfg = '0;
  pss_fault_t flt = '0;
  int err_count = 0, n_compared = 0, cyc = 0, n_pr = 0, n_ig = 0, e_pr = 0, e_ig = 0;
  pss_sequencer i_dut (.i_clk(clk), .i_resetn(rst_n), .i_start(st), .i_cfg(cfg),
    .i_order_valid(ov), .i_gen_done(gd), .i_layout_done(ld), .i_fault(flt),
    .o_print_order(po), .o_print(pr), .o_generate(gn), .o_feed(fd), .o_receive(rc),
    .o_start_ignored(ig), .o_err_valid(ev), .o_err_code(ec));
  pss_host_model i_host (.i_clk(clk), .i_pulse(pl), .i_hold(hd), .o_start(st));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pr_q <= pr;
    n_pr <= n_pr + int'(pr && !pr_q);
    n_ig <= n_ig + int'(ig);
    if (cyc > 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n); repeat (n) @(negedge clk); endtask
  task automatic pulse(ref logic s); s = 1; tick(1); s = 0; endtask
  task automatic wt();
    int k = 0;
    while (pr !== 1'b1 && k < 50) begin
      tick(1);
      k++;
    end
  endtask
  task automatic order(input int n);
    pulse(ov);
    for (int i = 0; i < n; i++) begin
      tick(4);
      chk(8'(gn), 8'(i == 0 || cfg.has_variables));
      if (gn === 1'b1) pulse(gd);
      if (!cfg.static_mode) pulse(pl);
      wt();
      chk(8'(pr), 8'h01);
      chk(8'(po), 8'h01);
      chk(8'(fd), 8'h01);
      chk(8'(gn), 8'(cfg.extended_mem && cfg.has_variables && i != n - 1));
      chk(8'(rc), 8'(cfg.extended_mem));
      flt.ribbon_out = 1;
      tick(1);
      flt = '0;
      chk(ec, 8'h0A);
      if (i == n - 1) hd = 0;
      if (!cfg.static_mode) begin
        tick(8);
        pulse(pl);
        e_ig++;
      end
      tick(10);
      pulse(ld);
    end
    e_pr += n;
    tick(6);
    chk(8'(po | pr), 8'h00);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(67043));
    tick(2);
    rst_n = 1;
    tick(2);
    chk(8'(rc), 8'h01);
    for (int i = 0; i < 5; i++) begin
      flt = 5'(5'h10 >> i);
      tick(1);
      chk(8'(ev), 8'(i != 3));
      if (i != 3) chk(ec, cd[i]);
    end
    flt = 5'h03;
    tick(1);
    chk(ec, 8'h08);
    flt = '0;
    for (int m = 0; m < 4; m++) begin
      cfg = '{m == 1, m == 3, m == 2, 1'($urandom), 8'($urandom_range(2, 4))};
      hd = (m == 1);
      order(int'(cfg.layouts));
      chk(8'(n_pr), 8'(e_pr));
      chk(8'(n_ig), 8'(e_ig));
    end
    tally_and_finish();
  end
endmodule
